/* core/lfs_status_bank.sv */
// Line fault status register bank with classic Wishbone slave and interrupt
// Overview of operation
// [R1] A read-only 48-bit open-load vector reports lines 0 to 47, bit n for line n.
// [R2] A read-only 16-bit short field reports lines 48 to 63, bit 0 for line 48 up to bit 15 for line 63.
// [R3] A read-only 48-bit short vector reports lines 0 to 47, bit n for line n.
// [R4] Each flag reads 1 when its line has a recorded warning and 0 when it has none.
// [R5] A read-only 16-bit open-load field in the low bits of its own register reports lines 48 to 63.
// [R6] Writes to flag registers are ignored and reserved bits read as zero.
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "lfs_map.svh"

module lfs_status_bank
(
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire lfs_pkg::lfs_lines_t open_set_i,
   input  wire lfs_pkg::lfs_lines_t short_set_i,
   input  wire logic               flags_clear_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire lfs_pkg::lfs_word_t wb_dat_i,
   output logic                    wb_ack_o,
   output lfs_pkg::lfs_word_t      wb_dat_o,
   output lfs_pkg::lfs_lines_t     open_load_line_flags_o,
   output lfs_pkg::lfs_lines_t     short_line_flags_o,
   output logic                    irq_o
);
   import lfs_pkg::*;

   // ==================================================
   // Flag storage
   // Detectors pulse set inputs; flags stick until the driver clears them
   lfs_lines_t                  open_flags;
   lfs_lines_t                  short_flags;
   logic [`LFS_IRQ_WIDTH-1:0]   irq_status;
   logic [`LFS_IRQ_WIDTH-1:0]   irq_mask;
   logic                        irq_q;

   wire lfs_lines_t next_open  = flags_clear_i ? open_set_i  : (open_flags  | open_set_i);  // R4
   wire lfs_lines_t next_short = flags_clear_i ? short_set_i : (short_flags | short_set_i); // R4

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         open_flags  <= `LFS_RESET_FLAGS;
         short_flags <= `LFS_RESET_FLAGS;
      end
      else
      begin
         open_flags  <= next_open;
         short_flags <= next_short;
      end
   end

   assign open_load_line_flags_o = open_flags;
   assign short_line_flags_o     = short_flags;

   // ==================================================
   // Bus decode
   wire logic req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic wr_req  = req & wb_we_i;
   wire logic hit_sts = (wb_adr_i == `LFS_OFS_IRQ_STATUS);
   wire logic hit_msk = (wb_adr_i == `LFS_OFS_IRQ_MASK);

   wire logic hit_open_a   = (wb_adr_i == `LFS_OFS_OPEN_LO_A);
   wire logic hit_open_b   = (wb_adr_i == `LFS_OFS_OPEN_LO_B);
   wire logic hit_open_hi  = (wb_adr_i == `LFS_OFS_OPEN_HI);
   wire logic hit_short_a  = (wb_adr_i == `LFS_OFS_SHORT_LO_A);
   wire logic hit_short_b  = (wb_adr_i == `LFS_OFS_SHORT_LO_B);
   wire logic hit_short_hi = (wb_adr_i == `LFS_OFS_SHORT_HI);

   // Only low 48 or 16 bits exist; upper word bits of each half read zero
   function automatic lfs_word_t pad_field(input logic [15:0] field);
      return {16'h0000, field};
   endfunction : pad_field

   lfs_word_t rd_word;
   always_comb
   begin
      if (hit_open_a)
         rd_word = open_flags[31:0];                 // R1
      else if (hit_open_b)
         rd_word = pad_field(open_flags[47:32]);     // R1 R6
      else if (hit_open_hi)
         rd_word = pad_field(open_flags[63:48]);     // R5 R6
      else if (hit_short_a)
         rd_word = short_flags[31:0];                // R3
      else if (hit_short_b)
         rd_word = pad_field(short_flags[47:32]);    // R3 R6
      else if (hit_short_hi)
         rd_word = pad_field(short_flags[63:48]);    // R2 R6
      else if (hit_sts)
         rd_word = {30'h0, irq_status};
      else if (hit_msk)
         rd_word = {30'h0, irq_mask};
      else
         rd_word = 32'h00000000;                     // R6
   end

   // ==================================================
   // Interrupt: new flag of either kind sets a sticky bit, set beats clear
   // Event only on a rising flag, so a held detector does not refire the interrupt
   function automatic logic new_flag(input lfs_lines_t set, input lfs_lines_t held);
      return |(set & ~held);
   endfunction : new_flag

   wire logic open_evt  = new_flag(open_set_i, open_flags);
   wire logic short_evt = new_flag(short_set_i, short_flags);
   wire logic [1:0] evt = {short_evt, open_evt};
   wire logic status_wr = wr_req & hit_sts & wb_sel_i[0];
   wire logic mask_wr   = wr_req & hit_msk & wb_sel_i[0];
   wire logic [1:0] w1c = status_wr ? wb_dat_i[1:0] : 2'h0;
   wire logic [1:0] next_status = (irq_status & ~w1c) | evt;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_status <= `LFS_RESET_IRQ;
         irq_mask   <= `LFS_RESET_IRQ;
         irq_q      <= 1'b0;
         wb_ack_o   <= 1'b0;
         wb_dat_o   <= 32'h00000000;
      end
      else
      begin
         irq_status <= next_status;
         if (mask_wr)
            irq_mask <= wb_dat_i[1:0];
         irq_q    <= |(next_status & (mask_wr ? wb_dat_i[1:0] : irq_mask));
         // Writes to flag words only acknowledge, nothing stored
         wb_ack_o <= req; // R6
         wb_dat_o <= (req & ~wb_we_i) ? rd_word : 32'h00000000;
      end
   end

   assign irq_o = irq_q;

   // ==================================================
   // Checks
   a_open_low_read: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      (req && !wb_we_i && wb_adr_i == `LFS_OFS_OPEN_LO_A) |=> (wb_ack_o && wb_dat_o == $past(open_flags[31:0])))
      else $error("open low word read wrong");
   a_short_high_read: assert property (@(posedge clk_i) disable iff (rst_i) // R2
      (req && !wb_we_i && wb_adr_i == `LFS_OFS_SHORT_HI) |=> (wb_dat_o == {16'h0000, $past(short_flags[63:48])}))
      else $error("short high field read wrong");
   a_short_low_read: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      (req && !wb_we_i && wb_adr_i == `LFS_OFS_SHORT_LO_B) |=> (wb_dat_o == {16'h0000, $past(short_flags[47:32])}))
      else $error("short low upper read wrong");
   a_flag_sticks: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      (!flags_clear_i && open_set_i[5]) |=> open_flags[5] [*1] ##0 (flags_clear_i || open_flags[5]) [*1])
      else $error("open flag did not stick");
   a_open_high_read: assert property (@(posedge clk_i) disable iff (rst_i) // R5
      (req && !wb_we_i && wb_adr_i == `LFS_OFS_OPEN_HI) |=> (wb_dat_o[31:16] == 16'h0000 &&
      wb_dat_o[15:0] == $past(open_flags[63:48])))
      else $error("open high field read wrong");
   a_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      (wr_req && wb_adr_i < `LFS_OFS_IRQ_STATUS && !flags_clear_i && open_set_i == 64'h0) |=> open_flags == $past(open_flags))
      else $error("flag write had effect");
   a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 (irq_o == |(irq_status & irq_mask)))
      else $error("interrupt level mismatch");
   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   // ==================================================
   // Bus, flag and interrupt checks
   a_open_mid_read: assert property (@(posedge clk_i) disable iff (rst_i) // R1
      (req && !wb_we_i && wb_adr_i == `LFS_OFS_OPEN_LO_B) |=> (wb_dat_o == {16'h0000, $past(open_flags[47:32])}))
      else $error("open low upper read wrong");

   a_short_word_read: assert property (@(posedge clk_i) disable iff (rst_i) // R3
      (req && !wb_we_i && wb_adr_i == `LFS_OFS_SHORT_LO_A) |=> (wb_dat_o == $past(short_flags[31:0])))
      else $error("short low word read wrong");

   a_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      (req && !wb_we_i && wb_adr_i > `LFS_OFS_IRQ_MASK) |=> (wb_dat_o == 32'h00000000))
      else $error("unmapped read not zero");

   a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
      req |=> wb_ack_o)
      else $error("request not acknowledged");

   a_idle_dat_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> (wb_dat_o == 32'h00000000))
      else $error("read data outside ack");

   a_write_dat_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && wb_we_i) |=> (wb_dat_o == 32'h00000000))
      else $error("write returned data");

   a_short_sticks: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      (!flags_clear_i && short_set_i[50]) |=> short_line_flags_o[50])
      else $error("short flag not set");

   a_set_beats_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      (flags_clear_i && open_set_i[7]) |=> open_flags[7])
      else $error("clear beat a new flag");

   a_clear_empties: assert property (@(posedge clk_i) disable iff (rst_i) // R4
      (flags_clear_i && open_set_i == 64'h0) |=> (open_flags == 64'h0))
      else $error("open flags not cleared");

   a_short_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i) // R6
      (wr_req && wb_adr_i < `LFS_OFS_IRQ_STATUS && !flags_clear_i && short_set_i == 64'h0)
      |=> short_flags == $past(short_flags))
      else $error("short flag write had effect");

   a_status_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      open_evt |=> irq_status[0])
      else $error("open event not recorded");

   a_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
      mask_wr |=> (irq_mask == $past(wb_dat_i[1:0])))
      else $error("mask write lost");

   a_status_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
      (status_wr && wb_dat_i[0] && !open_evt) |=> !irq_status[0])
      else $error("status bit not cleared");

endmodule : lfs_status_bank

/* include/lfs_map.svh */
// Register offsets, field positions and reset values of the line fault status bank
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH

// ==================================================
// Byte offsets, one 32-bit word each
`define LFS_OFS_OPEN_LO_A   8'h00
`define LFS_OFS_OPEN_LO_B   8'h04
`define LFS_OFS_OPEN_HI     8'h08
`define LFS_OFS_SHORT_LO_A  8'h0C
`define LFS_OFS_SHORT_LO_B  8'h10
`define LFS_OFS_SHORT_HI    8'h14
`define LFS_OFS_IRQ_STATUS  8'h18
`define LFS_OFS_IRQ_MASK    8'h1C

// ==================================================
// Field layout
`define LFS_LOW_LINES       48
`define LFS_HIGH_LINES      16
`define LFS_IRQ_OPEN_BIT    0
`define LFS_IRQ_SHORT_BIT   1
`define LFS_IRQ_WIDTH       2
`define LFS_RESET_FLAGS     64'h0000000000000000
`define LFS_RESET_IRQ       2'h0

`endif

/* include/lfs_pkg.sv */
// Types shared by the line fault status bank
package lfs_pkg;
   typedef logic [63:0] lfs_lines_t;
   typedef logic [31:0] lfs_word_t;
endpackage : lfs_pkg

/* dv/lfs_status_bank_test.sv */
// Self-checking random bench for the line fault status bank
`timescale 1ns/1ps
module lfs_status_bank_test;
   import lfs_pkg::*;
   logic       clk_i, rst_i, flags_clear_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [1:0] st, msk;
   lfs_lines_t open_set_i, short_set_i, open_load_line_flags_o, short_line_flags_o, eo, es;
   lfs_word_t  wb_dat_i, wb_dat_o, rd;
   int         fail_count, n_compared;
   lfs_status_bank DUT (.clk_i, .rst_i, .open_set_i, .short_set_i, .flags_clear_i, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .open_load_line_flags_o,
      .short_line_flags_o, .irq_o);
   // ==================================================
   // Helpers
   function lfs_word_t exp_word(input logic [7:0] a);
      case (a)
         8'h00: return eo[31:0];
         8'h04: return {16'h0000, eo[47:32]};
         8'h08: return {16'h0000, eo[63:48]};
         8'h0C: return es[31:0];
         8'h10: return {16'h0000, es[47:32]};
         8'h14: return {16'h0000, es[63:48]};
         8'h18: return {30'h0, st};
         8'h1C: return {30'h0, msk};
         default: return 32'h0;
      endcase
   endfunction : exp_word
   task check(input lfs_lines_t got, input lfs_lines_t exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task final_report;
      if (fail_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   task wb(input logic we, input logic [7:0] a, input lfs_word_t d);
      int t;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hF};
      t = 0;
      do begin @(negedge clk_i); t++; end while (wb_ack_o !== 1'b1 && t < 20);
      if (t >= 20) fail_count++;
      rd = wb_dat_o;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask : wb
   task pulse(input lfs_lines_t o, input lfs_lines_t s);
      @(posedge clk_i);
      {open_set_i, short_set_i} <= {o, s};
      @(posedge clk_i);
      {open_set_i, short_set_i} <= '0;
      st |= {|(s & ~es), |(o & ~eo)};
      eo |= o;
      es |= s;
   endtask : pulse
   task verify;
      for (int a = 0; a < 36; a += 4)
      begin
         wb(1'b0, a[7:0], 32'h0);
         check(rd, exp_word(a[7:0]));
      end
      check(open_load_line_flags_o, eo);
      check(short_line_flags_o, es);
   endtask : verify
   // ==================================================
   // Stimulus
   initial
   begin
      clk_i = 0;
      forever #25 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      final_report;
   end
   initial
   begin
      {rst_i, flags_clear_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {1'b1, 48'h0};
      {open_set_i, short_set_i, eo, es, st, msk, fail_count, n_compared} = '0;
      void'($urandom(32'h641F));
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      verify;
      pulse(64'h8001_8000_0000_0001, 64'h0001_8000_0000_8001);
      for (int i = 0; i < 12; i++)
      begin
         pulse({$urandom, $urandom} & {$urandom, $urandom}, {$urandom, $urandom} & {$urandom, $urandom});
         wb(1'b1, 8'(4 * ($urandom % 6)), $urandom);
         verify;
      end
      for (int m = 0; m < 4; m++)
      begin
         msk = m[1:0];
         wb(1'b1, 8'h1C, 32'(m));
         repeat (3) @(posedge clk_i);
         check(irq_o, |(st & msk));
      end
      wb(1'b1, 8'h18, 32'h1);
      st[0] = 1'b0;
      wb(1'b1, 8'h40, 32'hFFFF_FFFF);
      repeat (3) @(posedge clk_i);
      check(irq_o, |(st & msk));
      @(posedge clk_i);
      {flags_clear_i, open_set_i} <= {1'b1, 64'h0000_0000_0000_0010};
      @(posedge clk_i);
      {flags_clear_i, open_set_i} <= '0;
      st[0] = st[0] | (|(64'h0000_0000_0000_0010 & ~eo));
      {eo, es} = {64'h0000_0000_0000_0010, 64'h0};
      verify;
      final_report;
   end
endmodule : lfs_status_bank_test
